// ### hdl/slcr_bank.v
/*
  Lane 2 PHY control bank: four lane registers, one per even MAC, plus
  interrupt status and mask. Assumes a synchronous register port with
  one-cycle strobes and the lane status inputs synchronous to clock.
*/
`timescale 1ns/100ps
`include "slcr_regs.vh"

// How it works
// - Bit 0 reads weak signal, read-only
// - Bit 1 loops lane transmit to receive
// - Bits 2-3 select nominal driver current
// - Bits 4-7 set pre-emphasis ratio
// - Bits 8-11 trim the driver current
// - Bit 12 powers the lane down
// - Lane power-down leaves port state alone
// - Bit 13 holds lane logic in reset
// - Bit 14 resets shared lane 2/3 PLL
// - PLL reset is writable in all four lanes
// - Bit 15 disables framer, for bit tests
// - Four copies at the four printed offsets

module slcr_bank #(
  parameter NUM_MAC = 4,
  parameter LOOPBACK_WAIT_CYC = `SLCR_LOOPBACK_WAIT_CYC
) (
  input wire clock,
  input wire rst,
  input wire clkEn,
  input wire [`SLCR_ADDR_W-1:0] addr,
  input wire [31:0] wrData,
  input wire wrStb,
  input wire rdStb,
  output reg [31:0] rdData,
  input wire [NUM_MAC-1:0] weakSignal,
  output reg [NUM_MAC-1:0] loopbackEnable,
  output reg [2*NUM_MAC-1:0] driverCurrentSelect,
  output reg [4*NUM_MAC-1:0] preemphasisLevel,
  output reg [4*NUM_MAC-1:0] driverCurrentTrim,
  output reg [NUM_MAC-1:0] lanePowerDown,
  output reg [NUM_MAC-1:0] laneReset,
  output reg [NUM_MAC-1:0] pllReset,
  output reg [NUM_MAC-1:0] framerOff,
  output reg irq
);
  localparam W_CNT = 16;
  // Status bit layout: per-MAC groups of four
  localparam EV_WEAK = 0;
  localparam EV_LB_UNSAFE = 1;
  localparam EV_RELEASE_EARLY = 2;
  localparam EV_DRV_RSVD = 3;
  localparam EVW = 4 * NUM_MAC;

  reg [EVW-1:0] irqStatus_r;
  reg [EVW-1:0] irqMask_r;
  reg [EVW-1:0] events;
  wire [32*NUM_MAC-1:0] regValues;
  wire [NUM_MAC-1:0] weakRise;
  wire [NUM_MAC-1:0] lbChange;
  wire [NUM_MAC-1:0] hit;
  reg [31:0] rdMux;
  wire statusHit;
  wire maskHit;
  wire [EVW-1:0] irqStatus_nxt;

  assign statusHit = (addr == `SLCR_OFS_IRQ_STATUS);
  assign maskHit = (addr == `SLCR_OFS_IRQ_MASK);

  genvar g;
  generate
    for (g = 0; g < NUM_MAC; g = g + 1) begin : gMac
      localparam [31:0] OFS_FULL = `SLCR_OFS_MAC0 + g * (`SLCR_OFS_MAC2 - `SLCR_OFS_MAC0);
      reg [W_CNT-1:0] settle_r;
      wire [31:0] v;
      wire [`SLCR_ADDR_W-1:0] ofs;
      assign ofs = OFS_FULL[`SLCR_ADDR_W-1:0];
      assign hit[g] = (addr == ofs);
      slcr_lane_reg #(
        .HAS_PLL_RESET(1)
      ) uLane (
        .clock(clock),
        .rst(rst),
        .clkEn(clkEn),
        .wrEn(wrStb & hit[g]),
        .wrData(wrData),
        .weakSignalIn(weakSignal[g]),
        .regValue(v),
        .weakRise(weakRise[g]),
        .loopbackChange(lbChange[g])
      );
      assign regValues[32*g +: 32] = v;

      // Settle counter restarts on each loopback change; checks software timing
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          settle_r <= {W_CNT{1'b0}};
        end else if (clkEn) begin
          if (lbChange[g]) begin
            settle_r <= LOOPBACK_WAIT_CYC[W_CNT-1:0];
          end else if (settle_r != {W_CNT{1'b0}}) begin
            settle_r <= settle_r - {{W_CNT-1{1'b0}}, 1'b1};
          end
        end
      end

      always @* begin
        events[4*g+EV_WEAK] = weakRise[g];
        // Loopback moved while lane not held in reset
        events[4*g+EV_LB_UNSAFE] = lbChange[g] & ~v[`SLCR_BIT_LRST];
        // Lane reset released before the settle time ran out
        events[4*g+EV_RELEASE_EARLY] = clkEn & wrStb & hit[g] & v[`SLCR_BIT_LRST] &
          ~wrData[`SLCR_BIT_LRST] & (settle_r != {W_CNT{1'b0}});
        events[4*g+EV_DRV_RSVD] = clkEn & wrStb & hit[g] &
          (wrData[`SLCR_DRV_MSB:`SLCR_DRV_LSB] == `SLCR_DRV_RESERVED);
      end

      // Fields go to the transceiver through one output register; nothing here feeds port-level disable
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          loopbackEnable[g] <= 1'b0;
          driverCurrentSelect[2*g +: 2] <= 2'h0;
          preemphasisLevel[4*g +: 4] <= 4'h0;
          driverCurrentTrim[4*g +: 4] <= 4'h0;
          lanePowerDown[g] <= 1'b0;
          laneReset[g] <= 1'b0;
          pllReset[g] <= 1'b0;
          framerOff[g] <= 1'b0;
        end else if (clkEn) begin
          loopbackEnable[g] <= v[`SLCR_BIT_LOOPBACK];
          driverCurrentSelect[2*g +: 2] <= v[`SLCR_DRV_MSB:`SLCR_DRV_LSB];
          preemphasisLevel[4*g +: 4] <= v[`SLCR_PREEMPH_MSB:`SLCR_PREEMPH_LSB];
          driverCurrentTrim[4*g +: 4] <= v[`SLCR_TRIM_MSB:`SLCR_TRIM_LSB];
          lanePowerDown[g] <= v[`SLCR_BIT_LANE_POWER_DOWN];
          laneReset[g] <= v[`SLCR_BIT_LRST];
          pllReset[g] <= v[`SLCR_BIT_PLLRST];
          framerOff[g] <= v[`SLCR_BIT_FRMOFF];
        end
      end
    end
  endgenerate

  // Set beats write-one-to-clear in the same cycle
  assign irqStatus_nxt = (irqStatus_r & ~((clkEn & wrStb & statusHit) ? wrData[EVW-1:0] : {EVW{1'b0}})) | events;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irqStatus_r <= {EVW{1'b0}};
      irqMask_r <= {EVW{1'b0}};
      irq <= 1'b0;
    end else if (clkEn) begin
      irqStatus_r <= irqStatus_nxt;
      if (wrStb && maskHit) begin
        irqMask_r <= wrData[EVW-1:0];
      end
      irq <= |(irqStatus_nxt & ((wrStb && maskHit) ? wrData[EVW-1:0] : irqMask_r));
    end
  end

  integer i;
  always @* begin
    rdMux = 32'h00000000;
    if (statusHit) begin
      rdMux[EVW-1:0] = irqStatus_r;
    end else if (maskHit) begin
      rdMux[EVW-1:0] = irqMask_r;
    end else begin
      for (i = 0; i < NUM_MAC; i = i + 1) begin
        if (hit[i]) begin
          rdMux = regValues[32*i +: 32];
        end
      end
    end
  end

  // Unmapped addresses read zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData <= 32'h00000000;
    end else if (clkEn) begin
      rdData <= rdStb ? rdMux : 32'h00000000;
    end
  end
endmodule

// ### hdl/slcr_regs.vh
/*
  Register map, field layout and timing constants of the lane 2 PHY control bank.
  Assumes a byte-addressed register port; included by the bank modules.
*/
`ifndef SLCR_REGS_VH
`define SLCR_REGS_VH

`define SLCR_ADDR_W 20
`define SLCR_OFS_MAC0 20'h130B8
`define SLCR_OFS_MAC2 20'h132B8
`define SLCR_OFS_MAC4 20'h134B8
`define SLCR_OFS_MAC6 20'h136B8
`define SLCR_OFS_IRQ_STATUS 20'h13800
`define SLCR_OFS_IRQ_MASK 20'h13804

`define SLCR_BIT_WEAK 0
`define SLCR_BIT_LOOPBACK 1
`define SLCR_DRV_LSB 2
`define SLCR_DRV_MSB 3
`define SLCR_PREEMPH_LSB 4
`define SLCR_PREEMPH_MSB 7
`define SLCR_TRIM_LSB 8
`define SLCR_TRIM_MSB 11
`define SLCR_BIT_LANE_POWER_DOWN 12
`define SLCR_BIT_LRST 13
`define SLCR_BIT_PLLRST 14
`define SLCR_BIT_FRMOFF 15
`define SLCR_WMASK 32'h0000FFFE
`define SLCR_RESET_VAL 32'h00000000
`define SLCR_DRV_RESERVED 2'h3

`define SLCR_LOOPBACK_WAIT_NS 500
`define SLCR_CLK_PERIOD_NS 10
`define SLCR_LOOPBACK_WAIT_CYC ((`SLCR_LOOPBACK_WAIT_NS + `SLCR_CLK_PERIOD_NS - 1) / `SLCR_CLK_PERIOD_NS)

`endif

// ### hdl/slcr_lane_reg.v
/*
  One lane 2 PHY control register with its weak-signal event detector.
  Assumes the top decodes the address and gives one-cycle write strobes.
*/
`timescale 1ns/100ps
`include "slcr_regs.vh"

module slcr_lane_reg #(
  parameter HAS_PLL_RESET = 1
) (
  input wire clock,
  input wire rst,
  input wire clkEn,
  input wire wrEn,
  input wire [31:0] wrData,
  input wire weakSignalIn,
  output wire [31:0] regValue,
  output wire weakRise,
  output wire loopbackChange
);
  reg [15:1] ctrl_r;
  reg weak_r;
  wire [31:0] wmask;
  wire [15:1] ctrl_nxt;

  // Bit 14 only exists where the lane owns the shared PLL
  assign wmask = HAS_PLL_RESET ? `SLCR_WMASK : (`SLCR_WMASK & ~(32'h1 << `SLCR_BIT_PLLRST));
  assign ctrl_nxt = wrEn ? (wrData[15:1] & wmask[15:1]) : ctrl_r;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= 15'h0000;
      weak_r <= 1'b0;
    end else if (clkEn) begin
      ctrl_r <= ctrl_nxt;
      weak_r <= weakSignalIn;
    end
  end

  assign regValue = {16'h0000, ctrl_r, weak_r};
  assign weakRise = clkEn & weakSignalIn & ~weak_r;
  assign loopbackChange = clkEn & wrEn & (ctrl_nxt[`SLCR_BIT_LOOPBACK] != ctrl_r[`SLCR_BIT_LOOPBACK]);
endmodule

// ### testbench/slcr_bank_monitor.sv
/* Port checker for the lane PHY control bank.
   Assumes one clock domain; bound to every slcr_bank below. */
`timescale 1ns/100ps
module slcr_bank_monitor (
  input wire clock,
  input wire rst,
  input wire clkEn,
  input wire [19:0] addr,
  input wire [31:0] wrData,
  input wire wrStb,
  input wire rdStb,
  input wire [31:0] rdData,
  input wire [3:0] loopbackEnable,
  input wire [7:0] driverCurrentSelect,
  input wire [15:0] preemphasisLevel,
  input wire [15:0] driverCurrentTrim,
  input wire [3:0] lanePowerDown,
  input wire [3:0] laneReset,
  input wire [3:0] pllReset,
  input wire [3:0] framerOff,
  input wire irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  rd_idle_zero_a: assert property (clkEn && !rdStb |=> rdData == 32'h0)
    else $error("read data not idle zero");
  rd_upper_zero_a: assert property (rdStb |=> rdData[31:16] == 16'h0)
    else $error("upper read bits set");
  lane0_fields_a: assert property (
    clkEn && wrStb && addr == 20'h130B8 ##1 clkEn |=>
    {framerOff[0], pllReset[0], laneReset[0], lanePowerDown[0], driverCurrentTrim[3:0], preemphasisLevel[3:0],
    driverCurrentSelect[1:0], loopbackEnable[0]} == $past(wrData[15:1], 2)) else $error("lane0 fields wrong");
  lane6_loop_a: assert property (clkEn && wrStb && addr == 20'h136B8 ##1 clkEn |=>
    loopbackEnable[3] == $past(wrData[1], 2)) else $error("mac6 loopback wrong");
  unmapped_zero_a: assert property (rdStb && addr == 20'h10000 |=> rdData == 32'h0)
    else $error("unmapped read not zero");
  mask_off_a: assert property (
    clkEn && wrStb && addr == 20'h13804 && wrData[15:0] == 16'h0 ##1 clkEn |=> !irq)
    else $error("irq with mask clear");
  frozen_hold_a: assert property (!clkEn |=> $stable(rdData) && $stable(irq) && $stable(laneReset))
    else $error("state moved while frozen");
  reset_zero_a: assert property ($fell(rst) |-> rdData == 32'h0 && !irq && laneReset == 4'h0 &&
    loopbackEnable == 4'h0) else $error("outputs not zero after reset");
endmodule
bind slcr_bank slcr_bank_monitor i_slcr_bank_monitor (.*);

// ### testbench/slcr_lane_model.sv
/* Lane transceiver stand-in giving each lane's weak receive level.
   Assumes the bench sets the far-end cue per lane. */
`timescale 1ns/100ps
module slcr_lane_model (
  input wire [3:0] weakCmd,
  input wire [3:0] loopbackEnable,
  input wire [3:0] lanePowerDown,
  output wire [3:0] weakSignal
);
  // Dead receiver looks weak; own looped signal is never weak
  assign weakSignal = (weakCmd | lanePowerDown) & ~loopbackEnable;
endmodule

// ### testbench/slcr_testbench.sv
/* Self-checking bench for the lane PHY control bank.
   Assumes the bank, its lane model and its bound checker. */
`timescale 1ns/100ps
module testbench;
  reg clock = 1'b0, rst = 1'b1, clkEn = 1'b1, wrStb = 1'b0, rdStb = 1'b0;
  reg [19:0] addr = 20'h0;
  reg [31:0] wrData = 32'h0, d;
  reg [3:0] weakCmd = 4'h0;
  reg [4:0] c;
  reg [83:0] rows [0:4];
  wire [31:0] rdData;
  wire [3:0] weakSignal, loopbackEnable, lanePowerDown, laneReset, pllReset, framerOff;
  wire [7:0] driverCurrentSelect;
  wire [15:0] preemphasisLevel, driverCurrentTrim;
  wire irq;
  integer err_total = 0, comparisons = 0, i;
  // Short settle count keeps the run brief
  slcr_bank #(.LOOPBACK_WAIT_CYC(5)) i_slcr_bank (.*);
  slcr_lane_model i_slcr_lane_model (.*);
  initial begin
    forever #5 clock = ~clock;
  end
  task wr(input [19:0] a, input [31:0] v);
    begin
      @(posedge clock); addr <= a; wrData <= v; wrStb <= 1'b1;
      @(posedge clock); wrStb <= 1'b0;
    end
  endtask
  task rd(input [19:0] a);
    begin
      @(posedge clock); addr <= a; rdStb <= 1'b1;
      @(posedge clock); rdStb <= 1'b0;
      @(negedge clock); d = rdData;
    end
  endtask
  task settle;
    begin
      @(posedge clock); @(negedge clock);
    end
  endtask
  task chk(input [8*10-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d of %0d checks", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #20000 err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    rows[0] = {20'h130B8, 32'hFFFFFFFF, 32'h0000FFFE};
    rows[1] = {20'h132B8, 32'h0000A5A4, 32'h0000A5A4};
    rows[2] = {20'h134B8, 32'h00005A5B, 32'h00005A5A};
    rows[3] = {20'h136B8, 32'h0000C0F0, 32'h0000C0F0};
    rows[4] = {20'h10000, 32'hFFFFFFFF, 32'h00000000};
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      wr(rows[i][83:64], rows[i][63:32]);
      rd(rows[i][83:64]); chk("word", rows[i][31:0], d);
    end
    settle; d = {loopbackEnable, framerOff, pllReset, laneReset, lanePowerDown};
    chk("ctrl", 32'h0005BD35, d);
    for (c = 0; c < 16; c = c + 1) begin
      wr(20'h132B8, {20'h0, c[3:0], c[3:0], c[1:0], 2'h0}); settle;
      d = {driverCurrentTrim[7:4], preemphasisLevel[7:4], driverCurrentSelect[3:2]};
      chk("codes", {c[3:0], c[3:0], c[1:0]}, d);
    end
    wr(20'h130B8, 32'h00002000);
    repeat (10) @(posedge clock);
    wr(20'h130B8, 32'h0); rd(20'h13800);
    chk("status", 32'h0000028A, d);
    wr(20'h13800, 32'h0000FFFF); wr(20'h13804, 32'h1);
    weakCmd <= 4'h1; settle; settle;
    chk("irq", 32'h1, {31'h0, irq});
    rd(20'h130B8); chk("weak", 32'h1, d);
    wr(20'h13804, 32'h0); settle; chk("irq", 32'h0, {31'h0, irq});
    wr(20'h13804, 32'h1); settle; chk("irq", 32'h1, {31'h0, irq});
    wr(20'h13800, 32'h1); settle; chk("irq", 32'h0, {31'h0, irq});
    // Loopback moved under reset, then reset dropped too soon
    wr(20'h13804, 32'h00004000); wr(20'h136B8, 32'h00002000); wr(20'h136B8, 32'h00002002);
    wr(20'h136B8, 32'h00000002); settle; chk("early", 32'h1, {31'h0, irq});
    rd(20'h13800); chk("status", 32'h00004000, d);
    rd(20'h13804); chk("mask", 32'h00004000, d);
    @(posedge clock); clkEn <= 1'b0; wr(20'h132B8, 32'h0); clkEn <= 1'b1;
    rd(20'h132B8); chk("frozen", 32'h00000FFC, d);
    @(posedge clock); rst <= 1'b1; @(posedge clock); rst <= 1'b0;
    rd(20'h136B8); chk("rereset", 32'h0, d);
    print_verdict;
  end
endmodule
